/* shared/cell_monitor_map.svh */
// Purpose: Clock period, timing counts, cell count and calibration codes
// Assumes: 100 MHz reference clock
// Notes:   Included by the design modules
`ifndef CELL_MONITOR_MAP_SVH
`define CELL_MONITOR_MAP_SVH

`define CLK_PERIOD_NS      10
`define SAMPLE_TIME_US     120
`define SWEEP_WAIT_MS      50
`define SAMPLE_CYCLES      ((`SAMPLE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define SWEEP_WAIT_CYCLES  ((`SWEEP_WAIT_MS * 1000000) / `CLK_PERIOD_NS)
`define NUM_CELLS          10
`define CELL_SEL_W         4
`define CAL_OFF            3'b000
`define CAL_DIFF_ZERO      3'b001
`define CAL_DIFF_VREF      3'b010
`define CAL_VREF_DIRECT    3'b011
`define CAL_DIFF_2V5       3'b100
`define CAL_SH_VREF        3'b101
`define CAL_SH_2V5         3'b110

`endif

/* shared/cell_monitor_pkg.sv */
// Purpose: Types shared by the cell monitor design
// Assumes: Map header holds the numbers
// Notes:   Route encodings are one-hot
package cell_monitor_pkg;

   // Analog route of the cell voltage output pin
   typedef enum logic [9:0] {
      VR_GROUND     = 10'h001,
      VR_CELL_G015  = 10'h002,
      VR_CELL_G020  = 10'h004,
      VR_PACK       = 10'h008,
      VR_STACK      = 10'h010,
      VR_DIFF_ZERO  = 10'h020,
      VR_VREF_DIR   = 10'h040,
      VR_DIFF_VREF  = 10'h080,
      VR_DIFF_2V5   = 10'h100,
      VR_SH_REF     = 10'h200
   } vout_route_t;

   // Analog route of the current output pin
   typedef enum logic [2:0] {
      IR_GROUND = 3'b001,
      IR_NORMAL = 3'b010,
      IR_OFFSET = 3'b100
   } current_monitor_output_route_t;

   // Sampling sequencer states
   typedef enum logic [2:0] {
      SQ_WAIT   = 3'b001,
      SQ_SAMPLE = 3'b010,
      SQ_NEXT   = 3'b100
   } seq_state_t;

   // Monitor control fields from the host
   typedef struct packed {
      logic       gain_sel;
      logic       pack_en;
      logic       stack_en;
      logic       amp_en;
      logic [2:0] cal_code;
      logic [3:0] cell_sel;
   } vmon_ctrl_t;

   // Current monitor control fields
   typedef struct packed {
      logic gain_sel;
      logic offset_sel;
      logic enable;
   } imon_ctrl_t;

endpackage

/* hw/bypass_arbiter.sv */
// Purpose: Stand-alone bypass choice with adjacent-cell exclusion
// Assumes: Over-voltage flags already masked to used cells
// Notes:   A running cell keeps its bypass; between two new neighbours the lower index wins
`timescale 1ns/100ps
module bypass_arbiter
   import cell_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Cell state
   input  wire logic [9:0]  ov_in,
   input  wire logic [9:0]  used_in,
   // Result
   output logic [9:0]       active_out
);
`include "cell_monitor_map.svh"

   logic [9:0] active_r;
   logic [9:0] active_nxt;

   // Keep running cells, add others only when both neighbours idle
   always_comb begin
      active_nxt = '0;
      for (int i = 0; i < `NUM_CELLS; i++) begin
         if (ov_in[i] && used_in[i]) begin
            if (active_r[i]) begin
               active_nxt[i] = 1'b1;
            end else if (!(i > 0 && (active_r[i-1] || active_nxt[i-1])) &&
                         !(i < `NUM_CELLS-1 && active_r[i+1])) begin
               active_nxt[i] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         active_r <= '0;
      end else begin
         active_r <= active_nxt;
      end
   end

   assign active_out = active_r;

   no_adjacent_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (active_r & {1'b0, active_r[9:1]}) == 10'h000)
      else $error("adjacent cells bypassed together");

   release_ov_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ov_in[0] |=> !active_r[0])
      else $error("bypass kept after over-voltage release");

endmodule

/* hw/cell_monitor_balance_control.sv */
// Purpose: Gate safety, strap decode, monitor steering and cell bypass control
// Assumes: Pin-level inputs are asynchronous and synchronised here
// Notes:   Analog steering is given as one-hot route codes
`timescale 1ns/100ps
`include "cell_monitor_map.svh"
// Functional notes
// - Gates off until regulator power is good
// - Switch regulator source to stack when stable
// - Low rail drop kills gates and functions
// - Decode three straps into cell count
// - Delay strap high forces zero delays
// - Gain bit selects 0.15 or 0.20 scaling
// - Disabled cell output pin tied to ground
// - Pack enable routes pack voltage out
// - Stack enable routes stack voltage out
// - Calibration codes 001, 011, 010 routes
// - Calibration codes 100, 101, 110 routes
// - Current gain bit selects 50 or 10
// - Current output enable and offset select
// - Disabled current pin tied to ground
// - Host selects bypass per cell
// - Stand-alone bypasses over-voltage cell until release
// - Stand-alone never bypasses adjacent cells together; host mode passes the host choice as given
// - Bypass off during cell sampling
// - Sample 120 us per cell, wait 50 ms
module cell_monitor_balance_control
   import cell_monitor_pkg::*;
#(
   parameter int SWEEP_WAIT_CYC = `SWEEP_WAIT_CYCLES,
   parameter int SAMPLE_CYC     = `SAMPLE_CYCLES
)
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   // Power status pins
   input  wire logic        regulator_power_good_in,
   input  wire logic        high_rail_regulator_stable_in,
   input  wire logic        low_rail_regulator_stable_in,
   input  wire logic        low_rail_falling_in,
   // Straps
   input  wire logic        config_strap_bit0_in,
   input  wire logic        config_strap_bit1_in,
   input  wire logic        config_strap_bit2_in,
   input  wire logic        delay_override_strap_in,
   // Host control fields
   input  wire logic        host_mode_in,
   input  wire logic        charge_on_in,
   input  wire logic        discharge_on_in,
   input  wire logic        thermistor_enable_in,
   input  wire vmon_ctrl_t  vmon_ctrl_in,
   input  wire imon_ctrl_t  imon_ctrl_in,
   input  wire logic [9:0]  host_bypass_in,
   // Protection comparator results
   input  wire logic [9:0]  cell_ov_in,
   // Gate and supply outputs
   output logic             charge_gate_drive_out,
   output logic             discharge_gate_drive_out,
   output logic             high_rail_regulator_en_out,
   output logic             low_rail_regulator_en_out,
   output logic             thermistor_drive_output_out,
   output logic             regulator_src_stack_out,
   // Configuration outputs
   output logic [3:0]       cell_count_out,
   output logic [9:0]       cell_used_out,
   output logic             zero_delay_out,
   // Monitor steering
   output vout_route_t      vout_route_out,
   output logic [3:0]       vout_cell_out,
   output current_monitor_output_route_t      current_monitor_output_route_out,
   output logic             current_gain_50_out,
   // Sampling and bypass
   output logic             sampling_out,
   output logic [3:0]       sample_cell_out,
   output logic [9:0]       bypass_out
);
   // ***************************************************************
   // Reset release and input synchronisers
   // ***************************************************************
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   localparam int SYNC_W = 18;
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_s1_r;
   logic [SYNC_W-1:0] pin_s2_r;

   assign pin_raw = {cell_ov_in, delay_override_strap_in, config_strap_bit2_in,
                     config_strap_bit1_in, config_strap_bit0_in, low_rail_falling_in,
                     low_rail_regulator_stable_in, high_rail_regulator_stable_in,
                     regulator_power_good_in};

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end

   logic       pwr_good;
   logic       hi_stable;
   logic       lo_stable;
   logic       lo_fall;
   logic [2:0] strap;
   logic       dly_strap;
   logic [9:0] ov_sync;

   assign pwr_good  = pin_s2_r[0];
   assign hi_stable = pin_s2_r[1];
   assign lo_stable = pin_s2_r[2];
   assign lo_fall   = pin_s2_r[3];
   assign strap     = pin_s2_r[6:4];
   assign dly_strap = pin_s2_r[7];
   assign ov_sync   = pin_s2_r[17:8];

   // ***************************************************************
   // Power sequencing and gate safety
   // ***************************************************************
   logic src_stack_r;
   logic shut_r;

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         src_stack_r <= 1'b0;
      end else if (shut_r) begin
         src_stack_r <= 1'b0;
      end else if (hi_stable && lo_stable) begin
         src_stack_r <= 1'b1;
      end
   end

   // Shut state latches on low rail drop until power good drops
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         shut_r <= 1'b0;
      end else if (lo_fall) begin
         shut_r <= 1'b1;
      end else if (!pwr_good) begin
         shut_r <= 1'b0;
      end
   end

   logic func_ok;
   assign func_ok = pwr_good && !shut_r && !lo_fall;

   // Gate drives: 1 means gate turned on
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         charge_gate_drive_out       <= 1'b0;
         discharge_gate_drive_out    <= 1'b0;
         high_rail_regulator_en_out  <= 1'b0;
         low_rail_regulator_en_out   <= 1'b0;
         thermistor_drive_output_out <= 1'b0;
      end else begin
         charge_gate_drive_out       <= func_ok && charge_on_in;
         discharge_gate_drive_out    <= func_ok && discharge_on_in;
         high_rail_regulator_en_out  <= !shut_r && !lo_fall;
         low_rail_regulator_en_out   <= !shut_r && !lo_fall;
         thermistor_drive_output_out <= func_ok && thermistor_enable_in;
      end
   end
   assign regulator_src_stack_out = src_stack_r;

   gates_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      !pwr_good |=> !charge_gate_drive_out && !discharge_gate_drive_out)
      else $error("gate on while regulator unpowered");

   rail_drop_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      lo_fall |=> !low_rail_regulator_en_out && !thermistor_drive_output_out)
      else $error("function left on after low rail drop");

   src_switch_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      hi_stable && lo_stable && !shut_r |=> regulator_src_stack_out)
      else $error("regulator source not switched to stack");

   // ***************************************************************
   // Strap decode
   // ***************************************************************
   logic [3:0] count_nxt;

   always_comb begin
      case (strap)
         3'b001:  count_nxt = 4'h9;
         3'b010:  count_nxt = 4'h8;
         3'b011:  count_nxt = 4'h7;
         3'b100:  count_nxt = 4'h6;
         3'b101:  count_nxt = 4'h5;
         default: count_nxt = 4'hA;
      endcase
   end

   logic [9:0] used_nxt;
   // Unused inputs sit at the top of the stack: cell 0 drops first
   always_comb begin
      for (int i = 0; i < `NUM_CELLS; i++) begin
         used_nxt[i] = (i >= (`NUM_CELLS - int'(count_nxt)));
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cell_count_out <= 4'hA;
         cell_used_out  <= 10'h3FF;
         zero_delay_out <= 1'b0;
      end else begin
         cell_count_out <= count_nxt;
         cell_used_out  <= used_nxt;
         zero_delay_out <= dly_strap;
      end
   end

   strap_decode_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      strap == 3'b101 |=> cell_count_out == 4'h5)
      else $error("five cell strap misdecoded");

   zero_delay_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      dly_strap |=> zero_delay_out)
      else $error("zero delay not applied");

   // ***************************************************************
   // Monitor steering
   // ***************************************************************
   vout_route_t vr_nxt;
   always_comb begin
      vr_nxt = VR_GROUND;
      if (vmon_ctrl_in.pack_en) begin
         vr_nxt = VR_PACK;
      end else if (vmon_ctrl_in.stack_en) begin
         vr_nxt = VR_STACK;
      end else if (vmon_ctrl_in.amp_en) begin
         case (vmon_ctrl_in.cal_code)
            `CAL_DIFF_ZERO:   vr_nxt = VR_DIFF_ZERO;
            `CAL_VREF_DIRECT: vr_nxt = VR_VREF_DIR;
            `CAL_DIFF_VREF:   vr_nxt = VR_DIFF_VREF;
            `CAL_DIFF_2V5:    vr_nxt = VR_DIFF_2V5;
            `CAL_SH_VREF:     vr_nxt = VR_SH_REF;
            `CAL_SH_2V5:      vr_nxt = VR_SH_REF;
            default:          vr_nxt = vmon_ctrl_in.gain_sel ? VR_CELL_G020
                                                             : VR_CELL_G015;
         endcase
      end
   end

   current_monitor_output_route_t ir_nxt;
   always_comb begin
      if (!imon_ctrl_in.enable) begin
         ir_nxt = IR_GROUND;
      end else if (imon_ctrl_in.offset_sel) begin
         ir_nxt = IR_OFFSET;
      end else begin
         ir_nxt = IR_NORMAL;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         vout_route_out      <= VR_GROUND;
         vout_cell_out       <= 4'h0;
         current_monitor_output_route_out      <= IR_GROUND;
         current_gain_50_out <= 1'b0;
      end else begin
         vout_route_out      <= func_ok ? vr_nxt : VR_GROUND;
         vout_cell_out       <= vmon_ctrl_in.cell_sel;
         current_monitor_output_route_out      <= func_ok ? ir_nxt : IR_GROUND;
         current_gain_50_out <= imon_ctrl_in.gain_sel;
      end
   end

   vout_gnd_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      !vmon_ctrl_in.amp_en && !vmon_ctrl_in.pack_en && !vmon_ctrl_in.stack_en
      |=> vout_route_out == VR_GROUND)
      else $error("disabled cell output not grounded");

   current_monitor_output_gnd_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      !imon_ctrl_in.enable |=> current_monitor_output_route_out == IR_GROUND)
      else $error("disabled current output not grounded");

   // ***************************************************************
   // Sampling sequencer
   // ***************************************************************
   seq_state_t seq_r;
   logic [22:0] tmr_r;
   logic [3:0]  cell_r;

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         seq_r  <= SQ_WAIT;
         tmr_r  <= '0;
         cell_r <= 4'h0;
      end else begin
         case (seq_r)
            SQ_WAIT: begin
               if (tmr_r >= 23'(SWEEP_WAIT_CYC - 1)) begin
                  tmr_r  <= '0;
                  cell_r <= 4'h0;
                  seq_r  <= SQ_SAMPLE;
               end else begin
                  tmr_r <= tmr_r + 23'h1;
               end
            end
            SQ_SAMPLE: begin
               if (tmr_r >= 23'(SAMPLE_CYC - 1)) begin
                  tmr_r <= '0;
                  seq_r <= SQ_NEXT;
               end else begin
                  tmr_r <= tmr_r + 23'h1;
               end
            end
            SQ_NEXT: begin
               if (cell_r == 4'(`NUM_CELLS - 1)) begin
                  seq_r <= SQ_WAIT;
               end else begin
                  cell_r <= cell_r + 4'h1;
                  seq_r  <= SQ_SAMPLE;
               end
            end
            default: seq_r <= SQ_WAIT;
         endcase
      end
   end

   assign sampling_out    = seq_r != SQ_WAIT;
   assign sample_cell_out = cell_r;

   // ***************************************************************
   // Bypass selection
   // ***************************************************************
   logic [9:0] auto_bypass;

   bypass_arbiter u_arb (
      .clk_in     (ref_clk_in),
      .rst_n_in   (rst_n),
      .ov_in      (ov_sync & cell_used_out),
      .used_in    (cell_used_out),
      .active_out (auto_bypass)
   );

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         bypass_out <= '0;
      end else if (sampling_out || !func_ok) begin
         bypass_out <= '0;
      end else if (host_mode_in) begin
         bypass_out <= host_bypass_in;
      end else begin
         bypass_out <= auto_bypass;
      end
   end

   bypass_off_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
      sampling_out |=> bypass_out == 10'h000)
      else $error("bypass on while sampling");

endmodule

/* verification/host_ctrl_model.sv */
// Purpose: Host controller model that drives the monitor and bypass fields
// Assumes: Fields change just after the rising clock edge
// Notes:   Scale helper follows the host calibration arithmetic
`timescale 1ns/100ps
module host_ctrl_model
   import cell_monitor_pkg::*;
(
   // Clock
   input  wire logic  clk_in,
   // Control fields
   output vmon_ctrl_t vmon_ctrl_out,
   output imon_ctrl_t imon_ctrl_out,
   output logic [9:0] host_bypass_out,
   output logic       host_mode_out
);
   initial begin
      vmon_ctrl_out   = '0;
      imon_ctrl_out   = '0;
      host_bypass_out = '0;
      host_mode_out   = 1'b0;
   end

   task automatic set_vmon(input vmon_ctrl_t v);
      @(posedge clk_in);
      vmon_ctrl_out <= v;
   endtask

   task automatic set_imon(input imon_ctrl_t v);
      @(posedge clk_in);
      imon_ctrl_out <= v;
   endtask

   // Mode and per-cell bypass choice
   task automatic set_bypass(input logic mode, input logic [9:0] sel);
      @(posedge clk_in);
      host_mode_out   <= mode;
      host_bypass_out <= sel;
   endtask

   // Amplifier scale from zero, scaled-reference and direct readings
   function automatic real scale_factor(input real z, input real s, input real r);
      return (z - s) / r;
   endfunction
endmodule

/* verification/test_cell_monitor_balance_control.sv */
// Purpose: Self-checking bench for the cell monitor control block
// Assumes: Short sequencer counts set through parameters
// Notes:   Monitor and bypass host fields come from the partner model
`timescale 1ns/100ps
module test_cell_monitor_balance_control
   import cell_monitor_pkg::*;
;
   localparam int WAIT_C   = 50;
   localparam int SAMP_C   = 5;
   localparam int PERIOD_C = WAIT_C + 10 * (SAMP_C + 1);

   logic        clk, nrst, pgood, hstab, lstab, lfall, dstrap, chg_on, dsg_on, th_en;
   logic [2:0]  straps;
   logic [9:0]  ov, hbyp, used, byp;
   vmon_ctrl_t  vmon;
   imon_ctrl_t  imon;
   logic        hmode, chg_g, dsg_g, r1_en, r2_en, th_o, src_stk, zd, g50, smp;
   logic [3:0]  cnt, vcell, scell;
   vout_route_t vr;
   current_monitor_output_route_t ir;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   host_ctrl_model host (.clk_in(clk), .vmon_ctrl_out(vmon), .imon_ctrl_out(imon),
      .host_bypass_out(hbyp), .host_mode_out(hmode));

   cell_monitor_balance_control #(.SWEEP_WAIT_CYC(WAIT_C), .SAMPLE_CYC(SAMP_C)) dut (
      .ref_clk_in(clk), .nrst_in(nrst), .regulator_power_good_in(pgood),
      .high_rail_regulator_stable_in(hstab), .low_rail_regulator_stable_in(lstab),
      .low_rail_falling_in(lfall), .config_strap_bit0_in(straps[0]),
      .config_strap_bit1_in(straps[1]), .config_strap_bit2_in(straps[2]),
      .delay_override_strap_in(dstrap), .host_mode_in(hmode), .charge_on_in(chg_on),
      .discharge_on_in(dsg_on), .thermistor_enable_in(th_en), .vmon_ctrl_in(vmon),
      .imon_ctrl_in(imon), .host_bypass_in(hbyp), .cell_ov_in(ov),
      .charge_gate_drive_out(chg_g), .discharge_gate_drive_out(dsg_g),
      .high_rail_regulator_en_out(r1_en), .low_rail_regulator_en_out(r2_en),
      .thermistor_drive_output_out(th_o), .regulator_src_stack_out(src_stk),
      .cell_count_out(cnt), .cell_used_out(used), .zero_delay_out(zd),
      .vout_route_out(vr), .vout_cell_out(vcell), .current_monitor_output_route_out(ir),
      .current_gain_50_out(g50), .sampling_out(smp), .sample_cell_out(scell),
      .bypass_out(byp));

   //**********************************************************************
   // Clock, timeout and shared tasks
   //**********************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Settle inside the idle gap between sweeps
   task automatic wait_quiet();
      int run;
      run = 0;
      cycles(8);
      for (int i = 0; i < 500 && run < 4; i++) begin
         cycles(1);
         run = (smp === 1'b0) ? run + 1 : 0;
      end
   endtask

   //**********************************************************************
   // Scenarios
   //**********************************************************************
   task automatic t_power();
      check("src_stack", 16'(src_stk), 16'h0000);
      @(posedge clk);
      hstab <= 1'b1;
      lstab <= 1'b1;
      cycles(6);
      check("src_stack", 16'(src_stk), 16'h0001);
      check("gates", 16'({chg_g, dsg_g, r1_en, r2_en, th_o}), 16'h001F);
      @(posedge clk);
      pgood <= 1'b0;
      cycles(6);
      check("gates", 16'({chg_g, dsg_g}), 16'h0000);
      @(posedge clk);
      pgood <= 1'b1;
      lfall <= 1'b1;
      repeat (3) @(posedge clk);
      lfall <= 1'b0;
      cycles(6);
      check("shut", 16'({chg_g, dsg_g, r1_en, r2_en, th_o}), 16'h0000);
      @(posedge clk);
      pgood <= 1'b0;
      repeat (4) @(posedge clk);
      pgood <= 1'b1;
      cycles(6);
      check("gates", 16'({chg_g, dsg_g}), 16'h0003);
      @(posedge clk);
      chg_on <= 1'b0;
      th_en  <= 1'b0;
      cycles(4);
      check("gates", 16'({chg_g, dsg_g, th_o}), 16'h0002);
   endtask

   task automatic t_straps();
      logic [3:0] ec [8] = '{4'hA, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'hA, 4'hA};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         straps <= i[2:0];
         dstrap <= i[0];
         cycles(6);
         check("cell_count", 16'(cnt), 16'(ec[i]));
         check("cell_used", 16'(used), 16'(10'(10'h3FF << (10 - ec[i]))));
         check("zero_delay", 16'(zd), 16'(i[0]));
      end
   endtask

   task automatic t_vout();
      logic [10:0] vt [12] = '{11'h003, 11'h083, 11'h483, 11'h393, 11'h193, 11'h090,
         11'h0B0, 11'h0A0, 11'h0C0, 11'h0D0, 11'h0E0, 11'h4F3};
      vout_route_t ve [12] = '{VR_GROUND, VR_CELL_G015, VR_CELL_G020, VR_PACK, VR_STACK,
         VR_DIFF_ZERO, VR_VREF_DIR, VR_DIFF_VREF, VR_DIFF_2V5, VR_SH_REF, VR_SH_REF,
         VR_CELL_G020};
      for (int i = 0; i < 12; i++) begin
         host.set_vmon(vmon_ctrl_t'(vt[i]));
         cycles(3);
         check("vout_route", 16'(vr), 16'(ve[i]));
         if (i == 1 || i == 2) check("vout_cell", 16'(vcell), 16'h0003);
      end
      check("scale_factor", 16'(int'(host.scale_factor(1.0, 0.5, 0.25) * 4.0)), 16'h0008);
   endtask

   task automatic t_current_monitor_output();
      logic [2:0] it [5] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b101};
      current_monitor_output_route_t ie [5] = '{IR_GROUND, IR_GROUND, IR_NORMAL, IR_OFFSET, IR_NORMAL};
      for (int i = 0; i < 5; i++) begin
         host.set_imon(imon_ctrl_t'(it[i]));
         cycles(3);
         check("current_monitor_output_route", 16'(ir), 16'(ie[i]));
         if (it[i][0]) check("gain_50", 16'(g50), 16'(it[i][2]));
      end
   endtask

   task automatic t_bypass();
      host.set_bypass(1'b1, 10'h155);
      wait_quiet();
      check("host_bypass", 16'(byp), 16'h0155);
      for (int i = 0; i < 500 && smp !== 1'b1; i++) cycles(1);
      cycles(2);
      check("bypass_sampling", 16'(byp), 16'h0000);
      host.set_bypass(1'b0, 10'h000);
      ov <= 10'h0C4;
      wait_quiet();
      check("auto_bypass", 16'(byp), 16'h0044);
      @(posedge clk);
      ov <= 10'h084;
      wait_quiet();
      check("auto_bypass", 16'(byp), 16'h0084);
      @(posedge clk);
      ov <= 10'h000;
      wait_quiet();
      check("auto_bypass", 16'(byp), 16'h0000);
      @(posedge clk);
      straps <= 3'b101;
      ov <= 10'h011;
      wait_quiet();
      check("unused_bypass", 16'(byp), 16'h0000);
      @(posedge clk);
      ov <= 10'h000;
   endtask

   task automatic t_period();
      int low_run, t0, n, last;
      low_run = 0;
      t0 = 0;
      n = 0;
      last = 0;
      for (int i = 0; i < 1000 && n < 2; i++) begin
         cycles(1);
         if (smp === 1'b1 && low_run > 10) begin
            check("sample_cell", 16'(scell), 16'h0000);
            if (n == 1) begin
               check("sweep_period", 16'(cyc - t0), 16'(PERIOD_C));
               check("last_cell", 16'(last), 16'h0009);
            end
            t0 = cyc;
            n++;
         end
         if (smp === 1'b1) last = scell;
         low_run = (smp === 1'b0) ? low_run + 1 : 0;
      end
      check("sweep_count", 16'(n), 16'h0002);
   endtask

   //**********************************************************************
   // Main sequence
   //**********************************************************************
   initial begin
      nrst = 1'b0;
      {pgood, hstab, lstab, lfall, dstrap} = 5'b10000;
      {chg_on, dsg_on, th_en} = 3'b111;
      straps = 3'b000;
      ov = 10'h000;
      cycles(20);
      check("cell_count", 16'(cnt), 16'h000A);
      check("vout_route", 16'(vr), 16'(VR_GROUND));
      check("current_monitor_output_route", 16'(ir), 16'(IR_GROUND));
      @(posedge clk);
      nrst <= 1'b1;
      cycles(8);
      t_power();
      t_straps();
      t_vout();
      t_current_monitor_output();
      t_bypass();
      t_period();
      summarize();
   end
endmodule
